// *** seoc_pkg.sv ***
// Constants shared by the SMART enable / off-line command block
package seoc_pkg;

	// ----------------------------------------------------------------
	// Register byte offsets on the APB bus
	// ----------------------------------------------------------------
	localparam logic [7:0] OFF_FEATURE   = 8'h00;
	localparam logic [7:0] OFF_SECCNT    = 8'h04;
	localparam logic [7:0] OFF_SUBLOW    = 8'h08;
	localparam logic [7:0] OFF_SIGMID    = 8'h0c;
	localparam logic [7:0] OFF_SIGHIGH   = 8'h10;
	localparam logic [7:0] OFF_DEVSEL    = 8'h14;
	localparam logic [7:0] OFF_COMMAND   = 8'h18;
	localparam logic [7:0] OFF_STATUS    = 8'h1c;
	localparam logic [7:0] OFF_ERROR     = 8'h20;
	localparam logic [7:0] OFF_CONTROL   = 8'h24;
	localparam logic [7:0] OFF_STATE     = 8'h28;

	// ----------------------------------------------------------------
	// Command codes and signature values
	// ----------------------------------------------------------------
	localparam logic [7:0] OPC_SMART     = 8'hb0;
	localparam logic [7:0] FEAT_ENABLE   = 8'hd8;
	localparam logic [7:0] FEAT_EXEC     = 8'hd4;
	localparam logic [7:0] SIG_MID       = 8'h4f;
	localparam logic [7:0] SIG_HIGH      = 8'hc2;
	localparam logic [7:0] FAIL_MID      = 8'hf4;
	localparam logic [7:0] FAIL_HIGH     = 8'h2c;

	// ----------------------------------------------------------------
	// Subcommand codes
	// ----------------------------------------------------------------
	localparam logic [7:0] SUB_LAST_OFF  = 8'h03;
	localparam logic [7:0] SUB_SEL_OFF   = 8'h04;
	localparam logic [7:0] SUB_ABORT     = 8'h7f;
	localparam logic [7:0] SUB_CAP_FIRST = 8'h81;
	localparam logic [7:0] SUB_CAP_LAST  = 8'h83;
	localparam logic [7:0] SUB_SEL_CAP   = 8'h84;
	localparam int         SUB_CAP_BIT   = 7;

	// ----------------------------------------------------------------
	// Bit positions
	// ----------------------------------------------------------------
	localparam int ST_BSY   = 7;
	localparam int ST_DRDY  = 6;
	localparam int ST_DF    = 5;
	localparam int ST_DRQ   = 3;
	localparam int ST_ERR   = 0;
	localparam int ER_IDNF  = 4;
	localparam int ER_ABRT  = 2;
	localparam int DEV_BIT  = 4;
	localparam int CT_OWN   = 0;
	localparam int CT_ENSUP = 1;
	localparam int CT_EXSUP = 2;
	localparam int CT_SLSUP = 3;
	localparam int CT_FAIL  = 4;
	localparam int CT_FAULT = 5;
	localparam int CT_IDNF  = 6;

	// ----------------------------------------------------------------
	// Reset values and timing
	// ----------------------------------------------------------------
	localparam logic [7:0]  CONTROL_RST    = 8'h06;
	localparam logic [7:0]  BYTE_ZERO      = 8'h00;
	localparam logic [31:0] WORD_ZERO      = 32'h0000_0000;
	localparam int          ROUTINE_CYCLES = 10000;

	// Command sequencer states
	typedef enum logic [1:0] {
		CMD_IDLE,
		CMD_DECODE,
		CMD_CAPTIVE
	} seoc_state_t;

endpackage : seoc_pkg

// *** seoc_nv_state.sv ***
// Persistent SMART enabled flag with load from and save to non-volatile store
`timescale 1ns/1ps
`default_nettype none
module seoc_nv_state (
	input  wire logic i_clk,
	input  wire logic i_reset_n,
	input  wire logic i_nv_state,
	input  wire logic i_set_enable,
	output var  logic o_enabled,
	output var  logic o_nv_write,
	output var  logic o_nv_data
);

	logic sync1_q;
	logic sync2_q;
	logic loaded_q;
	logic settle1_q;
	logic settle2_q;

	// ----------------------------------------------------------------
	// Pin synchroniser
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
		end else begin
			sync1_q <= i_nv_state;
			sync2_q <= sync1_q;
		end
	end

	// ----------------------------------------------------------------
	// Stored state: loaded once after reset, set by an accepted enable
	// ----------------------------------------------------------------
	// Load waits until the synchroniser holds the pin, so the flag survives power cycles
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			settle1_q  <= 1'b0;
			settle2_q  <= 1'b0;
			loaded_q   <= 1'b0;
			o_enabled  <= 1'b0;
			o_nv_write <= 1'b0;
			o_nv_data  <= 1'b0;
		end else begin
			settle1_q  <= 1'b1;
			settle2_q  <= settle1_q;
			loaded_q   <= settle2_q;
			o_nv_write <= i_set_enable && !o_enabled;
			o_nv_data  <= 1'b1;
			if (i_set_enable) begin
				o_enabled <= 1'b1;
			end else if (!loaded_q) begin
				o_enabled <= sync2_q;
			end
		end
	end

endmodule : seoc_nv_state
`default_nettype wire

// *** seoc_routine_runner.sv ***
// Self-test and data collection sequencer, captive or background
`timescale 1ns/1ps
`default_nettype none
module seoc_routine_runner #(
	parameter int ROUTINE_CYCLES = seoc_pkg::ROUTINE_CYCLES
) (
	input  wire logic i_clk,
	input  wire logic i_reset_n,
	input  wire logic i_start,
	input  wire logic i_captive,
	input  wire logic i_abort,
	input  wire logic i_fail,
	output var  logic o_offline_busy,
	output var  logic o_captive_busy,
	output var  logic o_done,
	output var  logic o_fail
);

	logic [31:0] count_q;

	// ----------------------------------------------------------------
	// Routine timer
	// ----------------------------------------------------------------
	// A new start always restarts, which also drops a running routine
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			count_q        <= seoc_pkg::WORD_ZERO;
			o_offline_busy <= 1'b0;
			o_captive_busy <= 1'b0;
			o_done         <= 1'b0;
			o_fail         <= 1'b0;
		end else begin
			o_done <= 1'b0;
			if (i_start) begin
				count_q        <= 32'(ROUTINE_CYCLES - 1);
				o_offline_busy <= !i_captive;
				o_captive_busy <= i_captive;
				o_fail         <= 1'b0;
			end else if (i_abort && o_offline_busy) begin
				o_offline_busy <= 1'b0;
			end else if (o_offline_busy || o_captive_busy) begin
				if (count_q == seoc_pkg::WORD_ZERO) begin
					o_offline_busy <= 1'b0;
					o_captive_busy <= 1'b0;
					o_done         <= o_captive_busy;
					o_fail         <= i_fail;
				end else begin
					count_q <= count_q - 32'h0000_0001;
				end
			end
		end
	end

endmodule : seoc_routine_runner
`default_nettype wire

// *** seoc_smart_cmd.sv ***
// SMART enable and off-line immediate command interpreter with APB taskfile
//
// The APB slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module seoc_smart_cmd #(
	parameter int ROUTINE_CYCLES = seoc_pkg::ROUTINE_CYCLES
) (
	input  wire logic        I_SYS_CLK,
	input  wire logic        I_RESET_N,
	input  wire logic        I_PSEL,
	input  wire logic        I_PENABLE,
	input  wire logic        I_PWRITE,
	input  wire logic [7:0]  I_PADDR,
	input  wire logic [31:0] I_PWDATA,
	input  wire logic        I_NV_SMART_STATE,
	output var  logic        O_PREADY,
	output var  logic [31:0] O_PRDATA,
	output var  logic        O_PSLVERR,
	output var  logic        O_SMART_MONITOR_EN,
	output var  logic        O_NV_WRITE,
	output var  logic        O_NV_DATA,
	output var  logic        O_OFFLINE_BUSY,
	output var  logic        O_CAPTIVE_BUSY
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Assembles the status byte from its live bits
	function automatic logic [7:0] status_byte(input logic bsy, input logic df, input logic err);
		logic [7:0] s;
		s = seoc_pkg::BYTE_ZERO;
		s[seoc_pkg::ST_BSY]  = bsy;
		s[seoc_pkg::ST_DRDY] = 1'b1;
		s[seoc_pkg::ST_DF]   = df;
		s[seoc_pkg::ST_DRQ]  = 1'b0;
		s[seoc_pkg::ST_ERR]  = err;
		return s;
	endfunction : status_byte

	// Checks that both signature bytes hold the key
	function automatic logic sig_match(input logic [7:0] mid, input logic [7:0] high);
		return (mid == seoc_pkg::SIG_MID) && (high == seoc_pkg::SIG_HIGH);
	endfunction : sig_match

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	seoc_pkg::seoc_state_t state_q;
	logic [7:0]            feature_q;
	logic [7:0]            seccnt_q;
	logic [7:0]            sublow_q;
	logic [7:0]            sigmid_q;
	logic [7:0]            sighigh_q;
	logic [7:0]            devsel_q;
	logic [7:0]            opcode_q;
	logic [7:0]            control_q;
	logic [7:0]            error_q;
	logic                  bsy_q;
	logic                  df_q;
	logic                  launch_q;
	logic                  abort_run_q;
	logic                  set_enable_q;
	logic                  smart_en;
	logic                  run_done;
	logic                  run_fail;

	// ----------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------
	// Transfer qualifiers; a write lands only at the edge where ready is seen
	wire       access    = I_PSEL && I_PENABLE;
	wire       wr_fire   = access && I_PWRITE && O_PREADY;
	wire [7:0] wbyte     = I_PWDATA[7:0];
	wire       tf_write  = wr_fire && !bsy_q;

	// Known offsets; any other address answers with a slave error and no effect
	wire       addr_ok   = (I_PADDR == seoc_pkg::OFF_FEATURE) || (I_PADDR == seoc_pkg::OFF_SECCNT)
	                    || (I_PADDR == seoc_pkg::OFF_SUBLOW) || (I_PADDR == seoc_pkg::OFF_SIGMID)
	                    || (I_PADDR == seoc_pkg::OFF_SIGHIGH) || (I_PADDR == seoc_pkg::OFF_DEVSEL)
	                    || (I_PADDR == seoc_pkg::OFF_COMMAND) || (I_PADDR == seoc_pkg::OFF_STATUS)
	                    || (I_PADDR == seoc_pkg::OFF_ERROR) || (I_PADDR == seoc_pkg::OFF_CONTROL)
	                    || (I_PADDR == seoc_pkg::OFF_STATE);

	// ----------------------------------------------------------------
	// Read view
	// ----------------------------------------------------------------
	// Device select reads back with this device's own selection bit
	wire       own_dev   = control_q[seoc_pkg::CT_OWN];
	wire [7:0] dev_view  = {devsel_q[7:seoc_pkg::DEV_BIT + 1], own_dev, devsel_q[seoc_pkg::DEV_BIT - 1:0]};
	wire       err_sum   = |error_q;
	wire [7:0] stat_view = status_byte(bsy_q, df_q, err_sum);
	wire [7:0] state_view = {5'h00, O_CAPTIVE_BUSY, O_OFFLINE_BUSY, smart_en};

	// Read mux; the write-only command offset reads as zero
	wire [7:0] rd_byte   = (I_PADDR == seoc_pkg::OFF_FEATURE) ? feature_q :
	                       (I_PADDR == seoc_pkg::OFF_SECCNT)  ? seccnt_q  :
	                       (I_PADDR == seoc_pkg::OFF_SUBLOW)  ? sublow_q  :
	                       (I_PADDR == seoc_pkg::OFF_SIGMID)  ? sigmid_q  :
	                       (I_PADDR == seoc_pkg::OFF_SIGHIGH) ? sighigh_q :
	                       (I_PADDR == seoc_pkg::OFF_DEVSEL)  ? dev_view  :
	                       (I_PADDR == seoc_pkg::OFF_STATUS)  ? stat_view :
	                       (I_PADDR == seoc_pkg::OFF_ERROR)   ? error_q   :
	                       (I_PADDR == seoc_pkg::OFF_CONTROL) ? control_q :
	                       (I_PADDR == seoc_pkg::OFF_STATE)   ? state_view : seoc_pkg::BYTE_ZERO;

	// ----------------------------------------------------------------
	// Command decode
	// ----------------------------------------------------------------
	// Commands for the other device on the cable are ignored
	wire cmd_go     = tf_write && (I_PADDR == seoc_pkg::OFF_COMMAND)
	               && (devsel_q[seoc_pkg::DEV_BIT] == own_dev);

	// Opcode and feature pairs of the two supported requests
	wire is_smart   = opcode_q == seoc_pkg::OPC_SMART;
	wire is_enable  = is_smart && (feature_q == seoc_pkg::FEAT_ENABLE);
	wire is_exec    = is_smart && (feature_q == seoc_pkg::FEAT_EXEC);
	wire sig_ok     = sig_match(sigmid_q, sighigh_q);

	// Subcommand classes; selective codes count only when supported
	wire sel_sup    = control_q[seoc_pkg::CT_SLSUP];
	wire sub_off    = (sublow_q <= seoc_pkg::SUB_LAST_OFF)
	               || (sel_sup && (sublow_q == seoc_pkg::SUB_SEL_OFF));
	wire sub_abort  = sublow_q == seoc_pkg::SUB_ABORT;
	wire sub_cap    = ((sublow_q >= seoc_pkg::SUB_CAP_FIRST) && (sublow_q <= seoc_pkg::SUB_CAP_LAST))
	               || (sel_sup && (sublow_q == seoc_pkg::SUB_SEL_CAP));
	wire cap_class  = sublow_q[seoc_pkg::SUB_CAP_BIT];

	// Abort reasons; enable stays legal while the flag is off
	wire en_bad     = !control_q[seoc_pkg::CT_ENSUP] || !sig_ok;
	wire ex_bad     = !control_q[seoc_pkg::CT_EXSUP] || !smart_en || !sig_ok
	               || !(sub_off || sub_abort || sub_cap);

	// Conditions injected from the control register
	wire fault      = control_q[seoc_pkg::CT_FAULT];
	wire idnf       = control_q[seoc_pkg::CT_IDNF];

	// ----------------------------------------------------------------
	// APB response
	// ----------------------------------------------------------------
	// One wait state keeps ready and read data straight from flops
	// Costs a cycle per access, but no bus output is combinational
	always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			O_PREADY  <= 1'b0;
			O_PRDATA  <= seoc_pkg::WORD_ZERO;
			O_PSLVERR <= 1'b0;
		end else begin
			O_PREADY  <= access && !O_PREADY;
			O_PRDATA  <= {24'h00_0000, rd_byte};
			O_PSLVERR <= access && !O_PREADY && !addr_ok;
		end
	end

	// ----------------------------------------------------------------
	// Host-written parameters and control
	// ----------------------------------------------------------------
	// Writes while busy are dropped so an executing command sees stable inputs
	// Writes to read-only offsets fall through and change nothing
	always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			feature_q <= seoc_pkg::BYTE_ZERO;
			seccnt_q  <= seoc_pkg::BYTE_ZERO;
			sublow_q  <= seoc_pkg::BYTE_ZERO;
			devsel_q  <= seoc_pkg::BYTE_ZERO;
			control_q <= seoc_pkg::CONTROL_RST;
		end else if (tf_write) begin
			if (I_PADDR == seoc_pkg::OFF_FEATURE) begin
				feature_q <= wbyte;
			end
			if (I_PADDR == seoc_pkg::OFF_SECCNT) begin
				seccnt_q <= wbyte;
			end
			if (I_PADDR == seoc_pkg::OFF_SUBLOW) begin
				sublow_q <= wbyte;
			end
			if (I_PADDR == seoc_pkg::OFF_DEVSEL) begin
				devsel_q <= wbyte;
			end
			if (I_PADDR == seoc_pkg::OFF_CONTROL) begin
				control_q <= wbyte;
			end
		end
	end

	// ----------------------------------------------------------------
	// Command sequencer and completion outputs
	// ----------------------------------------------------------------
	// Signature bytes are shared between host writes and device results
	always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			state_q      <= seoc_pkg::CMD_IDLE;
			opcode_q     <= seoc_pkg::BYTE_ZERO;
			sigmid_q     <= seoc_pkg::BYTE_ZERO;
			sighigh_q    <= seoc_pkg::BYTE_ZERO;
			error_q      <= seoc_pkg::BYTE_ZERO;
			bsy_q        <= 1'b0;
			df_q         <= 1'b0;
			launch_q     <= 1'b0;
			abort_run_q  <= 1'b0;
			set_enable_q <= 1'b0;
		end else begin
			launch_q     <= 1'b0;
			abort_run_q  <= 1'b0;
			set_enable_q <= 1'b0;
			case (state_q)
				seoc_pkg::CMD_IDLE: begin
					// Signature bytes take host writes only while idle
					if (tf_write && (I_PADDR == seoc_pkg::OFF_SIGMID)) begin
						sigmid_q <= wbyte;
					end
					if (tf_write && (I_PADDR == seoc_pkg::OFF_SIGHIGH)) begin
						sighigh_q <= wbyte;
					end
					if (cmd_go) begin
						opcode_q <= wbyte;
						bsy_q    <= 1'b1;
						state_q  <= seoc_pkg::CMD_DECODE;
					end
				end
				seoc_pkg::CMD_DECODE: begin
					state_q  <= seoc_pkg::CMD_IDLE;
					bsy_q    <= 1'b0;
					// Results of the previous command are cleared first
					error_q  <= seoc_pkg::BYTE_ZERO;
					df_q     <= 1'b0;
					if (is_enable && !en_bad) begin
						set_enable_q <= 1'b1;
					end else if (is_exec && !ex_bad) begin
						if (idnf) begin
							error_q[seoc_pkg::ER_IDNF] <= 1'b1;
						end else if (sub_cap) begin
							bsy_q   <= 1'b1;
							state_q <= seoc_pkg::CMD_CAPTIVE;
						end else if (sub_abort) begin
							abort_run_q <= 1'b1;
						end else begin
							launch_q <= 1'b1;
						end
					end else begin
						// Unknown features also land here, covering disabled state
						error_q[seoc_pkg::ER_ABRT] <= 1'b1;
						df_q                       <= fault;
						if (is_exec && cap_class) begin
							sigmid_q  <= seoc_pkg::SIG_MID;
							sighigh_q <= seoc_pkg::SIG_HIGH;
						end
					end
				end
				seoc_pkg::CMD_CAPTIVE: begin
					// Busy holds until the runner reports the end of the test
					if (run_done) begin
						state_q <= seoc_pkg::CMD_IDLE;
						bsy_q   <= 1'b0;
						if (run_fail) begin
							error_q[seoc_pkg::ER_ABRT] <= 1'b1;
							df_q      <= fault;
							sigmid_q  <= seoc_pkg::FAIL_MID;
							sighigh_q <= seoc_pkg::FAIL_HIGH;
						end else begin
							sigmid_q  <= seoc_pkg::SIG_MID;
							sighigh_q <= seoc_pkg::SIG_HIGH;
						end
					end
				end
				default: begin
					// Unused state code falls back to idle
					state_q <= seoc_pkg::CMD_IDLE;
					bsy_q   <= 1'b0;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Persistent enable flag
	// ----------------------------------------------------------------
	// Flag is reloaded from the store after every reset; only the first enable saves
	seoc_nv_state u_nv (
		.i_clk        (I_SYS_CLK),
		.i_reset_n    (I_RESET_N),
		.i_nv_state   (I_NV_SMART_STATE),
		.i_set_enable (set_enable_q),
		.o_enabled    (smart_en),
		.o_nv_write   (O_NV_WRITE),
		.o_nv_data    (O_NV_DATA)
	);

	// Monitoring follows the stored flag
	always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			O_SMART_MONITOR_EN <= 1'b0;
		end else begin
			O_SMART_MONITOR_EN <= smart_en;
		end
	end

	// ----------------------------------------------------------------
	// Routine sequencer
	// ----------------------------------------------------------------
	// Captive starts leave decode together with the busy hold
	// Fail injection is sampled when the routine ends, not when it starts
	wire cap_start = (state_q == seoc_pkg::CMD_DECODE) && is_exec && !ex_bad && !idnf && sub_cap;

	seoc_routine_runner #(
		.ROUTINE_CYCLES (ROUTINE_CYCLES)
	) u_runner (
		.i_clk          (I_SYS_CLK),
		.i_reset_n      (I_RESET_N),
		.i_start        (launch_q || cap_start),
		.i_captive      (cap_start),
		.i_abort        (abort_run_q),
		.i_fail         (control_q[seoc_pkg::CT_FAIL]),
		.o_offline_busy (O_OFFLINE_BUSY),
		.o_captive_busy (O_CAPTIVE_BUSY),
		.o_done         (run_done),
		.o_fail         (run_fail)
	);

endmodule : seoc_smart_cmd
`default_nettype wire

// *** seoc_checker.sv ***
// Port assertions for the SMART command block
`timescale 1ns/1ps
`default_nettype none
module seoc_checker #(
	parameter int ROUTINE_CYCLES = 16
) (
	input wire logic        I_SYS_CLK, I_RESET_N, I_PSEL, I_PENABLE, I_PWRITE,
	input wire logic [7:0]  I_PADDR,
	input wire logic [31:0] I_PWDATA,
	input wire logic        I_NV_SMART_STATE, O_PREADY,
	input wire logic [31:0] O_PRDATA,
	input wire logic        O_PSLVERR, O_SMART_MONITOR_EN, O_NV_WRITE, O_NV_DATA, O_OFFLINE_BUSY, O_CAPTIVE_BUSY
);
	// ----------------------------------------------------------------
	// Bus and command properties
	// ----------------------------------------------------------------
	default clocking cb @(posedge I_SYS_CLK); endclocking
	default disable iff (!I_RESET_N);
	sequence one_wait_s; !O_PREADY ##1 O_PREADY; endsequence
	sequence captive_run_s; O_CAPTIVE_BUSY[*8] ##[1:400] !O_CAPTIVE_BUSY; endsequence
	wait_state_a: assert property (I_PSEL && !I_PENABLE |=> one_wait_s) else $error("pready late or early");
	ready_pulse_a: assert property (O_PREADY |=> !O_PREADY) else $error("pready held");
	ready_access_a: assert property (O_PREADY |-> I_PSEL && I_PENABLE) else $error("pready outside access");
	upper_zero_a: assert property (O_PREADY && !I_PWRITE |-> O_PRDATA[31:8] == 24'h0) else $error("prdata high bits");
	save_value_a: assert property (O_NV_WRITE |-> O_NV_DATA ##1 !O_NV_WRITE) else $error("bad save");
	monitor_on_a: assert property (O_NV_WRITE |=> O_SMART_MONITOR_EN) else $error("monitor not on");
	monitor_kept_a: assert property (!$fell(O_SMART_MONITOR_EN)) else $error("monitor dropped");
	busy_excl_a: assert property (!(O_OFFLINE_BUSY && O_CAPTIVE_BUSY)) else $error("both busy");
	captive_hold_a: assert property ($rose(O_CAPTIVE_BUSY) |-> captive_run_s) else $error("captive span");
endmodule : seoc_checker
bind seoc_smart_cmd seoc_checker #(.ROUTINE_CYCLES(ROUTINE_CYCLES)) u_chk (.I_SYS_CLK(I_SYS_CLK),
	.I_RESET_N(I_RESET_N), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR),
	.I_PWDATA(I_PWDATA), .I_NV_SMART_STATE(I_NV_SMART_STATE), .O_PREADY(O_PREADY), .O_PRDATA(O_PRDATA),
	.O_PSLVERR(O_PSLVERR), .O_SMART_MONITOR_EN(O_SMART_MONITOR_EN), .O_NV_WRITE(O_NV_WRITE),
	.O_NV_DATA(O_NV_DATA), .O_OFFLINE_BUSY(O_OFFLINE_BUSY), .O_CAPTIVE_BUSY(O_CAPTIVE_BUSY));
`default_nettype wire

// *** seoc_nv_model.sv ***
// Non-volatile store holding the SMART enabled flag
`timescale 1ns/1ps
`default_nettype none
module seoc_nv_model (
	input  wire logic i_clk,
	input  wire logic i_write,
	input  wire logic i_data,
	output var  logic o_state,
	output var  int   o_writes
);
	// Media starts with SMART off; writes counted for redundant saves
	initial begin
		o_state = 1'b0;
		o_writes = 0;
	end
	always @(posedge i_clk) begin
		if (i_write) begin
			o_state <= i_data;
			o_writes <= o_writes + 1;
		end
	end
endmodule : seoc_nv_model
`default_nettype wire

// *** test_seoc_smart_cmd.sv ***
// Self-checking bench for the SMART command block
`timescale 1ns/1ps
`default_nettype none
module test_seoc_smart_cmd;
	logic clk, rst_n, psel, pen, pwr, rdy, slv, mon, nvw, nvd, ob, cb, nvs, s;
	logic [7:0]  pa, ctl, rnd, bad;
	logic [31:0] pwd, prd, r;
	int          n_errors, compares, wc, i;
	// ----------------------------------------------------------------
	// Design, store and clock
	// ----------------------------------------------------------------
	seoc_smart_cmd #(.ROUTINE_CYCLES(200)) i_dut (.I_SYS_CLK(clk), .I_RESET_N(rst_n), .I_PSEL(psel),
		.I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(pa), .I_PWDATA(pwd), .I_NV_SMART_STATE(nvs),
		.O_PREADY(rdy), .O_PRDATA(prd), .O_PSLVERR(slv), .O_SMART_MONITOR_EN(mon), .O_NV_WRITE(nvw),
		.O_NV_DATA(nvd), .O_OFFLINE_BUSY(ob), .O_CAPTIVE_BUSY(cb));
	seoc_nv_model i_nv (.i_clk(clk), .i_write(nvw), .i_data(nvd), .o_state(nvs), .o_writes(wc));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	function automatic logic [7:0] lfsr(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction : lfsr
	task automatic close_out;
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : close_out
	task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", n, exp, seen);
		end
	endtask : chk
	// Bus cycle: request held until pready, one idle cycle after
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1; pen <= 1'b0; pwr <= w; pa <= a; pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		n = 0;
		do begin @(posedge clk); n++; end while (rdy !== 1'b1 && n < 50);
		if (n >= 50) begin n_errors++; close_out(); end
		r = prd; s = slv;
		psel <= 1'b0; pen <= 1'b0;
		@(posedge clk);
	endtask : apb
	// Command with expected error byte and signature readback
	task automatic cmd(input logic [7:0] f, l, m, h, e, em, eh);
		int n;
		apb(1, seoc_pkg::OFF_FEATURE, {24'h0, f}); apb(1, seoc_pkg::OFF_SUBLOW, {24'h0, l});
		apb(1, seoc_pkg::OFF_SIGMID, {24'h0, m}); apb(1, seoc_pkg::OFF_SIGHIGH, {24'h0, h});
		apb(1, seoc_pkg::OFF_COMMAND, {24'h0, seoc_pkg::OPC_SMART});
		n = 0;
		do begin apb(0, seoc_pkg::OFF_STATUS, 0); n++; end while (r[7] !== 1'b0 && n < 300);
		if (n >= 300) begin n_errors++; close_out(); end
		chk("status", r, {24'h0, 8'h40 | {7'h0, e != 0} | ((e[2] && ctl[5]) ? 8'h20 : 8'h0)});
		apb(0, seoc_pkg::OFF_ERROR, 0); chk("error", r, {24'h0, e});
		apb(0, seoc_pkg::OFF_SIGMID, 0); chk("mid", r, {24'h0, em});
		apb(0, seoc_pkg::OFF_SIGHIGH, 0); chk("high", r, {24'h0, eh});
	endtask : cmd
	task automatic setctl(input logic [7:0] v);
		ctl = v;
		apb(1, seoc_pkg::OFF_CONTROL, {24'h0, v});
	endtask : setctl
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	initial begin
		n_errors = 0; compares = 0; rnd = 8'h4e; ctl = 8'h06;
		rst_n = 1'b0; psel = 1'b0; pen = 1'b0; pwr = 1'b0; pa = 8'h0; pwd = 32'h0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		repeat (5) @(posedge clk);
		apb(0, seoc_pkg::OFF_STATUS, 0); chk("reset status", r, 32'h40);
		apb(0, 8'h2c, 0); chk("slverr", {31'h0, s}, 32'h1);
		cmd(8'hd4, 8'h0, 8'h4f, 8'hc2, 8'h04, 8'h4f, 8'hc2);
		rnd = lfsr(rnd); bad = (rnd == 8'h4f) ? 8'h00 : rnd;
		cmd(8'hd8, 8'h0, bad, 8'hc2, 8'h04, bad, 8'hc2);
		setctl(8'h26); cmd(8'hd8, 8'h0, 8'h4f, 8'h00, 8'h04, 8'h4f, 8'h00); setctl(8'h06);
		chk("still off", {31'h0, mon}, 32'h0);
		cmd(8'hd8, rnd, 8'h4f, 8'hc2, 8'h00, 8'h4f, 8'hc2);
		chk("monitor", {31'h0, mon}, 32'h1); chk("stored", {31'h0, nvs}, 32'h1);
		cmd(8'hd8, 8'h0, 8'h4f, 8'hc2, 8'h00, 8'h4f, 8'hc2); chk("saves", wc, 1);
		setctl(8'h04); cmd(8'hd8, 8'h0, 8'h4f, 8'hc2, 8'h04, 8'h4f, 8'hc2); setctl(8'h06);
		// Second reset: the enabled flag must come back from the store
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		repeat (5) @(posedge clk);
		chk("reloaded", {31'h0, mon}, 32'h1); chk("saves", wc, 1);
		apb(1, seoc_pkg::OFF_DEVSEL, 32'h10); apb(0, seoc_pkg::OFF_DEVSEL, 0); chk("dev", r & 32'h10, 0);
		apb(1, seoc_pkg::OFF_DEVSEL, 0);
		for (i = 0; i < 4; i++) begin
			cmd(8'hd4, i[7:0], 8'h4f, 8'hc2, 8'h00, 8'h4f, 8'hc2); chk("bg run", {31'h0, ob}, 32'h1);
			cmd(8'hd4, 8'h7f, 8'h4f, 8'hc2, 8'h00, 8'h4f, 8'hc2); chk("bg stop", {31'h0, ob}, 32'h0);
		end
		setctl(8'h0e); cmd(8'hd4, 8'h04, 8'h4f, 8'hc2, 8'h00, 8'h4f, 8'hc2);
		chk("sel run", {31'h0, ob}, 32'h1);
		cmd(8'hd4, 8'h84, 8'h4f, 8'hc2, 8'h00, 8'h4f, 8'hc2); setctl(8'h06);
		for (i = 8'h81; i <= 8'h83; i++) cmd(8'hd4, i[7:0], 8'h4f, 8'hc2, 8'h00, 8'h4f, 8'hc2);
		setctl(8'h16); cmd(8'hd4, 8'h82, 8'h4f, 8'hc2, 8'h04, 8'hf4, 8'h2c); setctl(8'h06);
		cmd(8'hd4, 8'h81, bad, 8'hc2, 8'h04, 8'h4f, 8'hc2);
		setctl(8'h46); cmd(8'hd4, 8'h00, 8'h4f, 8'hc2, 8'h10, 8'h4f, 8'hc2); setctl(8'h06);
		close_out();
	end
endmodule : test_seoc_smart_cmd
`default_nettype wire
